// >>> ifd_params.svh
// Constants for the instruction format decoder
`ifndef IFD_PARAMS_SVH
`define IFD_PARAMS_SVH
// Instruction word fields, bit 35 is the leftmost bit
`define IFD_OPC_HI 35
`define IFD_OPC_LO 24
`define IFD_FMT_HI 35
`define IFD_FMT_LO 33
`define IFD_D1_HI 23
`define IFD_D1_LO 12
`define IFD_D2_HI 11
`define IFD_D2_LO 0
`define IFD_REV_BIT 32
`define IFD_MULTI_BIT 31
`define IFD_DBL_BIT 30
`define IFD_RT_HI 25
`define IFD_RT_LO 24
`define IFD_COND_HI 30
`define IFD_COND_LO 28
`define IFD_SKIP_HI 27
`define IFD_SKIP_LO 24
`define IFD_REL_BIT 24
`define IFD_JOPC_HI 32
`define IFD_JOPC_LO 25
`define IFD_HJ_HI 23
`define IFD_HJ_LO 0
`define IFD_DSEL_BIT 32
`define IFD_VEXT_HI 31
`define IFD_VEXT_LO 30
// Descriptor subfields
`define IFD_X_BIT 11
`define IFD_MODE_HI 10
`define IFD_MODE_LO 6
`define IFD_MODE_CONST 5'h02
// Register port offsets and reset values
`define IFD_CTRL_OFS 4'h0
`define IFD_STAT_OFS 4'h4
`define IFD_CTRL_RST 1'h1
`endif

// >>> ifd_pkg.sv
// Types shared by the instruction format decoder
package ifd_pkg;
   // Instruction format classes
   typedef enum logic [2:0] {
      FMT_TWO_ADDR = 3'b000,
      FMT_THREE_ADDR = 3'b001,
      FMT_SHORT_JUMP = 3'b010,
      FMT_SKIP = 3'b011,
      FMT_JUMP = 3'b100,
      FMT_VECTOR = 3'b101,
      FMT_RSVD6 = 3'b110,
      FMT_RSVD7 = 3'b111
   } ifd_fmt_e;
   // Operand selections
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_FIRST_OPERAND = 3'b001,
      SEL_SECOND_OPERAND = 3'b010,
      SEL_ACC_A = 3'b011,
      SEL_ACC_B = 3'b100,
      SEL_POINTER = 3'b101
   } ifd_sel_e;
   // Result store order
   typedef enum logic [1:0] {
      ORDER_RESULT_TARGET_ONLY = 2'b00,
      ORDER_S2_S1_RESULT_TARGET = 2'b01,
      ORDER_S1_S2_RESULT_TARGET = 2'b10
   } ifd_order_e;
   // Hard trap requests
   typedef enum logic [2:0] {
      TRAP_NONE = 3'b000,
      TRAP_EXTRA_OPERAND = 3'b001,
      TRAP_ILLEGAL_OPERAND_MODE = 3'b010,
      TRAP_ILLEGAL_MEMORY = 3'b011,
      TRAP_ILLEGAL_OPCODE = 3'b100
   } ifd_trap_e;
   // Counter plus four times a word count, wraps modulo 2^31
   function automatic logic [30:0] ifd_rel_add(
      input logic [30:0] pc, input logic [30:0] words);
      return pc + {words[28:0], 2'b00};
   endfunction
endpackage

// >>> ifd_target_calc.sv
// Branch target and skip condition evaluation
`include "ifd_params.svh"
module ifd_target_calc import ifd_pkg::*; (
   // Decoded instruction
   input wire logic [2:0] i_format,
   input wire logic [35:0] i_instr,
   input wire logic [30:0] i_pc,
   // Evaluated operands
   input wire logic [35:0] i_first_operand_value,
   input wire logic [35:0] i_second_operand_value,
   input wire logic [30:0] i_jump_address,
   // Results
   output logic [30:0] o_jump_target,
   output logic o_branch_taken
);
   logic signed [35:0] a;
   logic signed [35:0] b;
   logic [3:0] skip_offset_field;
   logic [11:0] jof;
   assign a = i_first_operand_value;
   assign b = i_second_operand_value;
   assign skip_offset_field = i_instr[`IFD_SKIP_HI:`IFD_SKIP_LO];
   assign jof = i_instr[`IFD_D2_HI:`IFD_D2_LO];
   // Target and condition by format
   always_comb begin
      o_jump_target = i_pc;
      o_branch_taken = 1'b0;
      case (ifd_fmt_e'(i_format))
         FMT_SHORT_JUMP: begin
            // Unsigned displacement; wrap reaches backward
            o_jump_target = ifd_rel_add(i_pc,
               {7'h00, i_instr[`IFD_HJ_HI:`IFD_HJ_LO]});
            o_branch_taken = 1'b1;
         end
         FMT_SKIP: begin
            // Signed four-bit reach from the skip word
            o_jump_target = ifd_rel_add(i_pc,
               {{27{skip_offset_field[3]}}, skip_offset_field});
            case (i_instr[`IFD_COND_HI:`IFD_COND_LO])
               3'h0: o_branch_taken = (a == b);
               3'h1: o_branch_taken = (a != b);
               3'h2: o_branch_taken = (a < b);
               3'h3: o_branch_taken = (a <= b);
               3'h4: o_branch_taken = (a > b);
               3'h5: o_branch_taken = (a >= b);
               3'h6: o_branch_taken = 1'b1;
               default: o_branch_taken = 1'b0;
            endcase
         end
         FMT_JUMP: begin
            // Relative from own address, else evaluated address
            if (i_instr[`IFD_REL_BIT]) begin
               o_jump_target = ifd_rel_add(i_pc,
                  {{19{jof[11]}}, jof});
            end else begin
               o_jump_target = i_jump_address;
            end
         end
         default: o_jump_target = i_pc;
      endcase
   end
endmodule

// >>> ifd_vector_ctl.sv
// Vector length span and pointer register selection
`include "ifd_params.svh"
module ifd_vector_ctl (
   // Instruction and length register
   input wire logic [35:0] i_instr,
   input wire logic [35:0] i_vector_length_register,
   // Results
   output logic [38:0] o_vector_span,
   output logic [2:0] o_ptr_mask,
   output logic [1:0] o_result_target_ptr
);
   logic [1:0] extra;
   logic [1:0] prec;
   assign extra = i_instr[`IFD_VEXT_HI:`IFD_VEXT_LO];
   assign prec = i_instr[`IFD_RT_HI:`IFD_RT_LO];
   // Span in quarterwords: element count times size
   always_comb begin
      o_vector_span = {3'h0, i_vector_length_register}
         << prec;
      // Extra vectors use pointer zero, one, two in turn
      case (extra)
         2'h0: o_ptr_mask = 3'h0;
         2'h1: o_ptr_mask = 3'h1;
         2'h2: o_ptr_mask = 3'h3;
         default: o_ptr_mask = 3'h7;
      endcase
      // Next pointer after the sources, last one at most
      o_result_target_ptr = (extra == 2'h3) ? 2'h2 : extra;
   end
endmodule

// >>> ifd_decoder.sv
// Instruction format decoder: one registered decode stage
`include "ifd_params.svh"
module ifd_decoder import ifd_pkg::*; (
   // Clock and reset
   input wire logic i_ref_clk,
   input wire logic i_rstn,
   // Instruction from fetch with its address
   input wire logic i_instr_valid,
   input wire logic [35:0] i_instr,
   input wire logic [30:0] i_pc,
   // Evaluated operands and registers
   input wire logic [35:0] i_first_operand_value,
   input wire logic [35:0] i_second_operand_value,
   input wire logic [30:0] i_jump_address,
   input wire logic [35:0] i_vector_length_register,
   // Register port
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [31:0] o_reg_rdata,
   // Decode result strobe and identity
   output logic o_valid,
   output logic [11:0] o_opcode,
   output ifd_fmt_e o_format,
   // Operand routing
   output ifd_sel_e o_result_target,
   output ifd_sel_e o_first_source,
   output ifd_sel_e o_second_source,
   output logic o_first_source_double,
   output logic o_second_source_double,
   output ifd_order_e o_store_order,
   output logic o_reverse,
   output logic [11:0] o_first_descriptor,
   output logic [11:0] o_second_descriptor,
   // Branching
   output logic o_branch_taken,
   output logic [30:0] o_jump_target,
   output logic o_need_extended_word,
   output logic [7:0] o_jump_opcode_field,
   // Vector control
   output logic [38:0] o_vector_span,
   output logic [2:0] o_vector_ptr_mask,
   output logic o_vector_result_target_ptr,
   output logic [1:0] o_vector_result_target_index,
   // Hard trap request
   output logic o_trap_valid,
   output ifd_trap_e o_trap_code
);
   // Whole module state
   typedef struct packed {
      logic ctrl_enable;
      ifd_fmt_e last_fmt;
      ifd_trap_e last_trap;
      logic [15:0] trap_count;
      logic [31:0] rdata;
      logic valid;
      logic [11:0] opcode;
      ifd_fmt_e fmt;
      ifd_sel_e result_target;
      ifd_sel_e src1;
      ifd_sel_e src2;
      logic dbl1;
      logic dbl2;
      ifd_order_e order;
      logic reverse;
      logic [11:0] d1;
      logic [11:0] d2;
      logic taken;
      logic [30:0] target;
      logic need_ext;
      logic [7:0] jump_opcode_field;
      logic [38:0] vspan;
      logic [2:0] vmask;
      logic vdest_ptr;
      logic [1:0] vdest;
      logic trap_valid;
      ifd_trap_e trap;
   } ifd_state_s;

   ifd_state_s st_reg; // Registered state
   ifd_state_s st_next; // Next state

   // Field views of the incoming word
   ifd_fmt_e fmt; // Format class
   logic [11:0] d1; // First descriptor
   logic [11:0] d2; // Second descriptor
   logic [1:0] rt; // Routing field
   logic rev; // Reverse form
   logic multi; // More than two results
   logic dbl; // Normal form wants double first source
   logic go; // Instruction accepted this cycle
   logic d2_reg; // Second descriptor names a register
   logic d2_const; // Second descriptor is a constant
   logic [30:0] calc_target;
   logic calc_taken;
   logic [38:0] vec_span;
   logic [2:0] vec_mask;
   logic [1:0] vec_result_target;

   assign fmt = ifd_fmt_e'(i_instr[`IFD_FMT_HI:`IFD_FMT_LO]);
   assign d1 = i_instr[`IFD_D1_HI:`IFD_D1_LO];
   assign d2 = i_instr[`IFD_D2_HI:`IFD_D2_LO];
   assign rt = i_instr[`IFD_RT_HI:`IFD_RT_LO];
   assign rev = i_instr[`IFD_REV_BIT];
   assign multi = i_instr[`IFD_MULTI_BIT];
   assign dbl = i_instr[`IFD_DBL_BIT];
   assign go = i_instr_valid && st_reg.ctrl_enable;
   // Register mode: high four mode bits all zero
   assign d2_reg = (d2[`IFD_MODE_HI:`IFD_MODE_LO+1] == 4'h0);
   assign d2_const =
      (d2[`IFD_MODE_HI:`IFD_MODE_LO] == `IFD_MODE_CONST);

   // Branch target and skip test
   ifd_target_calc u_target (
      .i_format(i_instr[`IFD_FMT_HI:`IFD_FMT_LO]),
      .i_instr(i_instr),
      .i_pc(i_pc),
      .i_first_operand_value(i_first_operand_value),
      .i_second_operand_value(i_second_operand_value),
      .i_jump_address(i_jump_address),
      .o_jump_target(calc_target),
      .o_branch_taken(calc_taken)
   );

   // Vector span and pointers
   ifd_vector_ctl u_vector (
      .i_instr(i_instr),
      .i_vector_length_register(i_vector_length_register),
      .o_vector_span(vec_span),
      .o_ptr_mask(vec_mask),
      .o_result_target_ptr(vec_result_target)
   );

   // Next state: register port and one decode per cycle
   always_comb begin
      st_next = st_reg;
      st_next.valid = 1'b0;
      st_next.taken = 1'b0;
      st_next.trap_valid = 1'b0;
      st_next.rdata = 32'h0000_0000;
      // Control write gates the decoder
      if (i_reg_wr && i_reg_addr == `IFD_CTRL_OFS) begin
         st_next.ctrl_enable = i_reg_wdata[0];
      end
      // Read data stands one cycle after the strobe
      if (i_reg_rd) begin
         case (i_reg_addr)
            `IFD_CTRL_OFS: st_next.rdata = {31'h0, st_reg.ctrl_enable};
            `IFD_STAT_OFS: st_next.rdata = {st_reg.trap_count,
               10'h000, st_reg.last_trap, st_reg.last_fmt};
            default: st_next.rdata = 32'h0000_0000;
         endcase
      end
      if (go) begin
         // Defaults for every format
         st_next.valid = 1'b1;
         st_next.opcode = i_instr[`IFD_OPC_HI:`IFD_OPC_LO];
         st_next.fmt = fmt;
         st_next.result_target = SEL_NONE;
         st_next.src1 = SEL_NONE;
         st_next.src2 = SEL_NONE;
         st_next.dbl1 = 1'b0;
         st_next.dbl2 = 1'b0;
         st_next.order = ORDER_RESULT_TARGET_ONLY;
         st_next.reverse = 1'b0;
         // Descriptors pass through; accumulators are legal here
         st_next.d1 = d1;
         st_next.d2 = d2;
         st_next.taken = calc_taken;
         st_next.target = calc_target;
         st_next.need_ext = 1'b0;
         st_next.jump_opcode_field = 8'h00;
         st_next.vdest_ptr = 1'b0;
         st_next.trap = TRAP_NONE;
         case (fmt)
            FMT_TWO_ADDR: begin
               // Operand count in the routing bits
               st_next.result_target = (rt == 2'h0) ? SEL_NONE
                  : SEL_FIRST_OPERAND;
               st_next.src2 = (rt[1]) ? SEL_SECOND_OPERAND
                  : SEL_NONE;
               // Unused descriptor fields must be zero, else an extra-operand trap
               if ((rt == 2'h0 && (d1 != 12'h000 || d2 != 12'h000))
                  || (rt == 2'h1 && d2 != 12'h000)) begin
                  st_next.trap = TRAP_EXTRA_OPERAND;
               end
            end
            FMT_THREE_ADDR: begin
               // Routing field picks destination and first source
               case (rt)
                  2'h0: begin
                     st_next.result_target = SEL_FIRST_OPERAND;
                     st_next.src1 = SEL_FIRST_OPERAND;
                  end
                  2'h1: begin
                     st_next.result_target = SEL_FIRST_OPERAND;
                     st_next.src1 = SEL_ACC_A;
                  end
                  2'h2: begin
                     st_next.result_target = SEL_ACC_A;
                     st_next.src1 = SEL_FIRST_OPERAND;
                  end
                  default: begin
                     st_next.result_target = SEL_ACC_B;
                     st_next.src1 = SEL_FIRST_OPERAND;
                  end
               endcase
               st_next.src2 = SEL_SECOND_OPERAND;
               st_next.dbl1 = dbl;
               st_next.reverse = rev;
               if (rev) begin
                  // Operand roles and precisions trade places
                  st_next.src1 = SEL_SECOND_OPERAND;
                  st_next.src2 = st_next.result_target == SEL_ACC_A
                     ? SEL_FIRST_OPERAND : (rt == 2'h1
                     ? SEL_ACC_A : SEL_FIRST_OPERAND);
                  st_next.dbl1 = 1'b0;
                  st_next.dbl2 = dbl;
               end
               if (multi) begin
                  st_next.order = rev ? ORDER_S1_S2_RESULT_TARGET
                     : ORDER_S2_S1_RESULT_TARGET;
               end
            end
            FMT_SHORT_JUMP: begin
               st_next.result_target = SEL_NONE;
            end
            FMT_SKIP: begin
               // Both operands feed the compare
               st_next.src1 = SEL_FIRST_OPERAND;
               st_next.src2 = SEL_SECOND_OPERAND;
            end
            FMT_JUMP: begin
               // Operation field and data operand
               st_next.jump_opcode_field = i_instr[`IFD_JOPC_HI:`IFD_JOPC_LO];
               st_next.src1 = SEL_FIRST_OPERAND;
               if (!i_instr[`IFD_REL_BIT]) begin
                  // Extended word when the X bit asks for it
                  st_next.need_ext = d2[`IFD_X_BIT];
                  if (d2_reg) begin
                     st_next.trap = TRAP_ILLEGAL_OPERAND_MODE;
                  end else if (d2_const) begin
                     st_next.trap = TRAP_ILLEGAL_MEMORY;
                  end
               end
            end
            FMT_VECTOR: begin
               // Two-address layout; elements stay in memory
               st_next.src1 = SEL_FIRST_OPERAND;
               st_next.src2 = SEL_SECOND_OPERAND;
               st_next.vdest_ptr = i_instr[`IFD_DSEL_BIT];
               st_next.result_target = i_instr[`IFD_DSEL_BIT]
                  ? SEL_POINTER : SEL_FIRST_OPERAND;
            end
            default: begin
               st_next.trap = TRAP_ILLEGAL_OPCODE;
            end
         endcase
         st_next.vspan = vec_span;
         st_next.vmask = vec_mask;
         st_next.vdest = vec_result_target;
         // A trap suppresses any branch
         if (st_next.trap != TRAP_NONE) begin
            st_next.trap_valid = 1'b1;
            st_next.taken = 1'b0;
            st_next.last_trap = st_next.trap;
            if (st_reg.trap_count != 16'hFFFF) begin
               st_next.trap_count = st_reg.trap_count + 16'h0001;
            end
         end
         st_next.last_fmt = fmt;
      end
   end

   // State register
   always_ff @(posedge i_ref_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_reg <= '0;
         st_reg.ctrl_enable <= `IFD_CTRL_RST;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs straight from the state register
   assign o_reg_rdata = st_reg.rdata;
   assign o_valid = st_reg.valid;
   assign o_opcode = st_reg.opcode;
   assign o_format = st_reg.fmt;
   assign o_result_target = st_reg.result_target;
   assign o_first_source = st_reg.src1;
   assign o_second_source = st_reg.src2;
   assign o_first_source_double = st_reg.dbl1;
   assign o_second_source_double = st_reg.dbl2;
   assign o_store_order = st_reg.order;
   assign o_reverse = st_reg.reverse;
   assign o_first_descriptor = st_reg.d1;
   assign o_second_descriptor = st_reg.d2;
   assign o_branch_taken = st_reg.taken;
   assign o_jump_target = st_reg.target;
   assign o_need_extended_word = st_reg.need_ext;
   assign o_jump_opcode_field = st_reg.jump_opcode_field;
   assign o_vector_span = st_reg.vspan;
   assign o_vector_ptr_mask = st_reg.vmask;
   assign o_vector_result_target_ptr = st_reg.vdest_ptr;
   assign o_vector_result_target_index = st_reg.vdest;
   assign o_trap_valid = st_reg.trap_valid;
   assign o_trap_code = st_reg.trap;

   // Checks on the decoded outputs
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);

   property p_route_b;
      go && fmt == FMT_THREE_ADDR && rt == 2'h3 && !rev |=>
         o_result_target == SEL_ACC_B &&
         o_first_source == SEL_FIRST_OPERAND &&
         o_second_source == SEL_SECOND_OPERAND;
   endproperty
   a_route_b: assert property (p_route_b)
      else $error("routing 3 not sent to accumulator B");

   property p_route_a;
      go && fmt == FMT_THREE_ADDR && rt == 2'h2 && !rev |=>
         o_valid && o_result_target == SEL_ACC_A;
   endproperty
   a_route_a: assert property (p_route_a)
      else $error("routing 2 not sent to accumulator A");

   property p_reverse;
      go && fmt == FMT_THREE_ADDR && rt == 2'h1 && rev |=>
         o_first_source == SEL_SECOND_OPERAND &&
         o_second_source == SEL_ACC_A;
   endproperty
   a_reverse: assert property (p_reverse)
      else $error("reverse form did not swap sources");

   property p_prec;
      go && fmt == FMT_THREE_ADDR && rev |=>
         o_second_source_double == $past(dbl) &&
         !o_first_source_double;
   endproperty
   a_prec: assert property (p_prec)
      else $error("reverse form did not swap precisions");

   property p_order;
      go && fmt == FMT_THREE_ADDR && multi |=>
         o_store_order == ($past(rev) ? ORDER_S1_S2_RESULT_TARGET
         : ORDER_S2_S1_RESULT_TARGET);
   endproperty
   a_order: assert property (p_order)
      else $error("wrong multi-result store order");

   property p_extra;
      go && fmt == FMT_TWO_ADDR && rt == 2'h1 && d2 != 12'h000
         |=> o_trap_valid && o_trap_code == TRAP_EXTRA_OPERAND
         ##1 (!o_trap_valid || $past(go));
   endproperty
   a_extra: assert property (p_extra)
      else $error("unused descriptor did not trap");

   property p_short;
      go && fmt == FMT_SHORT_JUMP |=> o_branch_taken &&
         o_jump_target == 31'($past(i_pc) +
         {$past(i_instr[`IFD_HJ_HI:`IFD_HJ_LO]), 2'b00});
   endproperty
   a_short: assert property (p_short)
      else $error("short jump target wrong");

   property p_jrel;
      go && fmt == FMT_JUMP && i_instr[`IFD_REL_BIT] |=>
         31'(o_jump_target - $past(i_pc)) ==
         {{17{$past(d2[11])}}, $past(d2), 2'b00};
   endproperty
   a_jrel: assert property (p_jrel)
      else $error("relative jump offset wrong");

   property p_jabs;
      go && fmt == FMT_JUMP && !i_instr[`IFD_REL_BIT] && d2_reg
         |=> o_trap_valid && !o_branch_taken &&
         o_trap_code == TRAP_ILLEGAL_OPERAND_MODE;
   endproperty
   a_jabs: assert property (p_jabs)
      else $error("absolute jump to register did not trap");
endmodule

// >>> ifd_fetch_model.sv
// Fetch-side partner model feeding words and operands to the decoder
module ifd_fetch_model (
   // Clock
   input wire logic i_ref_clk,
   // Instruction, address and evaluated operands
   output logic o_instr_valid,
   output logic [35:0] o_instr,
   output logic [30:0] o_pc,
   output logic [35:0] o_op_a,
   output logic [35:0] o_op_b,
   output logic [30:0] o_jump_address,
   output logic [35:0] o_length
);
   timeunit 1ns;
   timeprecision 1ps;
   // Absolute target and element count stay fixed for the whole run
   initial begin
      o_instr_valid = 1'b0;
      o_instr = 36'h0;
      o_pc = 31'h0;
      o_op_a = 36'h0;
      o_op_b = 36'h0;
      o_jump_address = 31'h1230;
      o_length = 36'h64;
   end
   // One word for one edge; the released word and address are scrambled, operands held
   task automatic send(input logic [35:0] ins, input logic [30:0] pc,
         input logic [35:0] a, input logic [35:0] b);
      @(posedge i_ref_clk);
      o_instr_valid <= 1'b1;
      o_instr <= ins;
      o_pc <= pc;
      o_op_a <= a;
      o_op_b <= b;
      @(posedge i_ref_clk);
      o_instr_valid <= 1'b0;
      o_instr <= ~ins;
      o_pc <= ~pc;
   endtask
endmodule

// >>> instr_format_decoder_test.sv
// Self-checking bench for the instruction format decoder
module instr_format_decoder_test import ifd_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   // Routing tables indexed by the routing field, entry 0 lowest
   localparam logic [11:0] DST = {SEL_ACC_B, SEL_ACC_A,
      SEL_FIRST_OPERAND, SEL_FIRST_OPERAND};
   localparam logic [11:0] SRC = {SEL_FIRST_OPERAND, SEL_FIRST_OPERAND,
      SEL_ACC_A, SEL_FIRST_OPERAND};
   // Skip outcome per condition code for operands -1 and 1
   localparam logic [7:0] TAKE = 8'h4E;
   logic i_ref_clk, i_rstn, i_reg_wr, i_reg_rd, i_instr_valid;
   logic [3:0] i_reg_addr;
   logic [31:0] i_reg_wdata, o_reg_rdata;
   logic [35:0] i_instr, i_first_operand_value, i_second_operand_value;
   logic [35:0] i_vector_length_register;
   logic [30:0] i_pc, i_jump_address, o_jump_target;
   logic [2:0] o_format, o_result_target, o_first_source;
   logic [2:0] o_second_source, o_trap_code;
   logic [1:0] o_store_order, o_vector_result_target_index;
   logic o_valid, o_reverse, o_first_source_double;
   logic o_second_source_double, o_branch_taken, o_trap_valid;
   logic [7:0] o_jump_opcode_field;
   logic [38:0] o_vector_span;
   logic [11:0] o_opcode, o_first_descriptor, o_second_descriptor;
   logic [2:0] o_vector_ptr_mask;
   logic o_need_extended_word, o_vector_result_target_ptr;
   int fail_count, check_count;
   // Far side: fetch and operand evaluation
   ifd_fetch_model fetch (.i_ref_clk, .o_instr_valid(i_instr_valid),
      .o_instr(i_instr), .o_pc(i_pc), .o_op_a(i_first_operand_value),
      .o_op_b(i_second_operand_value), .o_jump_address(i_jump_address),
      .o_length(i_vector_length_register));
   ifd_decoder uut (.i_ref_clk, .i_rstn, .i_instr_valid, .i_instr, .i_pc,
      .i_first_operand_value, .i_second_operand_value, .i_jump_address,
      .i_vector_length_register, .i_reg_addr, .i_reg_wdata, .i_reg_wr,
      .i_reg_rd, .o_reg_rdata, .o_valid, .o_opcode, .o_format,
      .o_result_target, .o_first_source, .o_second_source,
      .o_first_source_double, .o_second_source_double, .o_store_order,
      .o_reverse, .o_first_descriptor, .o_second_descriptor,
      .o_branch_taken, .o_jump_target, .o_need_extended_word,
      .o_jump_opcode_field, .o_vector_span, .o_vector_ptr_mask,
      .o_vector_result_target_ptr, .o_vector_result_target_index, .o_trap_valid,
      .o_trap_code);
   // 40 MHz reference clock
   initial begin
      i_ref_clk = 1'b0;
      forever #12.5 i_ref_clk = ~i_ref_clk;
   end
   // Compare one observed value against its expectation
   task automatic check(input logic [38:0] seen, input logic [38:0] exp);
      check_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Single exit point of the run
   task automatic conclude();
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // One-cycle register write
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b1;
      i_reg_addr <= a;
      i_reg_wdata <= d;
      @(posedge i_ref_clk);
      i_reg_wr <= 1'b0;
   endtask
   // One-cycle read; data are only valid in the following cycle
   task automatic reg_read(input logic [3:0] a, input logic [31:0] exp);
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b1;
      i_reg_addr <= a;
      @(posedge i_ref_clk);
      i_reg_rd <= 1'b0;
      #1 check(o_reg_rdata, exp);
   endtask
   // Issue a word, then wait a bounded time for its result strobe
   task automatic decode(input logic [35:0] ins, input logic [30:0] pc,
         input logic [35:0] a, input logic [35:0] b);
      int n;
      n = 0;
      fetch.send(ins, pc, a, b);
      #1;
      while (o_valid !== 1'b1 && n < 4) begin
         @(posedge i_ref_clk);
         #1 n++;
      end
      if (n == 4) begin
         fail_count++;
         conclude();
      end
   endtask
   // Main sequence
   initial begin
      i_rstn = 1'b0;
      i_reg_wr = 1'b0;
      i_reg_rd = 1'b0;
      i_reg_addr = 4'h0;
      i_reg_wdata = 32'h0;
      fail_count = 0;
      check_count = 0;
      repeat (8) @(posedge i_ref_clk);
      i_rstn <= 1'b1;
      reg_read(4'h0, 32'h1);
      reg_read(4'h4, 32'h0);
      reg_read(4'h8, 32'h0);
      // Every routing code, normal form, several results
      for (int t = 0; t < 4; t++) begin
         decode({3'h1, 3'h2, 4'h0, 2'(t), 24'h400400}, 31'h100, 0, 0);
         check(o_format, FMT_THREE_ADDR);
         check(o_opcode, {6'h0A, 4'h0, 2'(t)});
         check({o_first_descriptor, o_second_descriptor}, 24'h400400);
         check(o_result_target, DST[3*t +: 3]);
         check(o_first_source, SRC[3*t +: 3]);
         check(o_second_source, SEL_SECOND_OPERAND);
         check(o_store_order, ORDER_S2_S1_RESULT_TARGET);
      end
      // Reverse form with double first source in normal form
      decode({3'h1, 3'h7, 4'h0, 2'h1, 24'h400400}, 31'h100, 0, 0);
      check(o_reverse, 1'b1);
      check(o_first_source, SEL_SECOND_OPERAND);
      check(o_second_source, SEL_ACC_A);
      check({o_first_source_double, o_second_source_double}, 2'h1);
      check(o_store_order, ORDER_S1_S2_RESULT_TARGET);
      // Short jump wrapping past the top of the address space
      decode({12'h400, 24'h000010}, 31'h7FFFFFF0, 0, 0);
      check(o_jump_target, 31'h30);
      check(o_branch_taken, 1'b1);
      // All skip conditions at the most negative reach
      for (int c = 0; c < 8; c++) begin
         decode({5'h0C, 3'(c), 4'h8, 24'h0}, 31'h100, '1, 36'h1);
         check(o_branch_taken, TAKE[c]);
         if (TAKE[c])
            check(o_jump_target, 31'hE0);
      end
      decode({5'h0C, 3'h6, 4'h7, 24'h0}, 31'h100, 0, 0);
      check(o_jump_target, 31'h11C);
      // Relative jump at the most negative offset
      decode({3'h4, 8'h5A, 1'b1, 24'h400800}, 31'h4000, 0, 0);
      check(o_jump_opcode_field, 8'h5A);
      check(o_jump_target, 31'h2000);
      // Absolute jump through memory, then register and constant
      decode({3'h4, 8'h5A, 1'b0, 24'h400C00}, 31'h4000, 0, 0);
      check({o_trap_valid, o_jump_target}, 32'h1230);
      check(o_need_extended_word, 1'b1);
      decode({3'h4, 8'h5A, 1'b0, 24'h400000}, 31'h4000, 0, 0);
      check({o_trap_valid, o_trap_code}, 4'hA);
      decode({3'h4, 8'h5A, 1'b0, 24'h400080}, 31'h4000, 0, 0);
      check({o_trap_valid, o_trap_code}, 4'hB);
      // One-operand two-address word with a stray second descriptor
      decode({10'h0, 2'h1, 24'h400001}, 31'h100, 0, 0);
      check({o_trap_valid, o_trap_code}, 4'h9);
      // Vector: halfword elements, two extra vectors, pointer result
      decode({3'h5, 3'h6, 4'h0, 2'h1, 24'h400400}, 31'h100, 0, 0);
      check(o_vector_span, 39'h0C8);
      check(o_vector_result_target_index, 2'h2);
      check(o_vector_ptr_mask, 3'h3);
      check(o_vector_result_target_ptr, 1'b1);
      // Decoding switched off: the word must be ignored
      reg_write(4'h0, 32'h0);
      fetch.send(36'h0, 31'h0, 0, 0);
      #1 check(o_valid, 1'b0);
      reg_write(4'h0, 32'h1);
      reg_read(4'h0, 32'h1);
      // Three traps so far, last one the stray descriptor, vector last
      reg_read(4'h4, 32'h0003000D);
      conclude();
   end
endmodule
